// file: mcad_chk_sva.sv
// concurrent checks on the ports of the operand and alu decode core
`timescale 1ns/1ps
`default_nettype none
`include "mcad_map.vh"
module mcad_chk (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // inputs watched
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire [4:0] general_register_operand,
   input wire jump_register_operand,
   input wire bootstrap_init_mode,
   // outputs watched
   input wire [31:0] gen_reg_select_ff,
   input wire [2:0] gen_reg_class_ff,
   input wire [1:0] jump_reg_select_ff,
   input wire [12:0] bias_enable,
   input wire [47:0] threshold_level,
   input wire exec_done_ff,
   input wire exec_denied_ff,
   input wire exec_unknown_ff,
   input wire [8:0] flags_ff
);
   // ----------------------------------------
   // instruction classes
   // ----------------------------------------
   wire is_add = instr_valid && instr_word[15:10] == `MCAD_OPC_ADD && !instr_word[6];
   wire is_addi = instr_valid && instr_word[15:10] == `MCAD_OPC_ADDI;
   wire is_and = instr_valid && instr_word[15:3] == `MCAD_OPC_AND;
   wire is_bias = instr_valid && instr_word[15:5] == `MCAD_OPC_BIAS;
   wire is_chth = instr_valid && instr_word[15:7] == `MCAD_OPC_CHTH;
   wire is_unk = instr_valid && !(is_add || is_addi || is_and || is_bias || is_chth);
   function automatic [2:0] cls(input [4:0] c);
      cls = c < 8 ? 0 : c < 10 ? 1 : c < 12 ? 2 : c < 16 ? 3 : c < 20 ? 4 : c < 23 ? 5 : c < 31 ? 6 : 7;
   endfunction
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sel_onehot_a: assert property ($past(presetn) |-> gen_reg_select_ff == 32'h1 << $past(general_register_operand)) else $error("operand select wrong");
   reg_class_a: assert property ($past(presetn) |-> gen_reg_class_ff == cls($past(general_register_operand))) else $error("operand class wrong");
   jump_pick_a: assert property ($past(presetn) |-> jump_reg_select_ff == ($past(jump_register_operand) ? 2'h2 : 2'h1)) else $error("jump select wrong");
   add_done_a: assert property (is_add || is_addi |=> exec_done_ff && !flags_ff[3] && flags_ff[4] == flags_ff[0]) else $error("add result flags wrong");
   add_mask_keep_a: assert property (is_add || is_addi |=> flags_ff[8:7] == $past(flags_ff[8:7])) else $error("add touched mask flags");
   and_keep_a: assert property (is_and |=> exec_done_ff && flags_ff[6:0] == $past(flags_ff[6:0])) else $error("mask touched add flags");
   odd_word_a: assert property (is_unk |=> exec_unknown_ff && !exec_done_ff) else $error("unknown word executed");
   bias_hold_a: assert property (!is_bias |=> $stable(bias_enable)) else $error("bias moved without order");
   bias_act_a: assert property (is_bias |=> exec_done_ff != exec_denied_ff) else $error("bias not answered");
   chth_act_a: assert property (is_chth |=> exec_done_ff != exec_denied_ff) else $error("change not answered");
   boot_odd_a: assert property ($past(bootstrap_init_mode) && $past(bootstrap_init_mode, 2) |-> (threshold_level & 48'h000038e38e38) == 48'h0) else $error("source level not forced");
   add_seen_c: cover property (is_add);
   denied_seen_c: cover property (exec_denied_ff);
   boot_seen_c: cover property (bootstrap_init_mode && is_chth);
endmodule
bind mcad_core mcad_chk mcad_chk_i (.pclk(pclk), .presetn(presetn), .instr_valid(instr_valid),
   .instr_word(instr_word), .general_register_operand(general_register_operand),
   .jump_register_operand(jump_register_operand), .bootstrap_init_mode(bootstrap_init_mode),
   .gen_reg_select_ff(gen_reg_select_ff), .gen_reg_class_ff(gen_reg_class_ff),
   .jump_reg_select_ff(jump_reg_select_ff), .bias_enable(bias_enable),
   .threshold_level(threshold_level), .exec_done_ff(exec_done_ff),
   .exec_denied_ff(exec_denied_ff), .exec_unknown_ff(exec_unknown_ff), .flags_ff(flags_ff));
`default_nettype wire

// file: mcad_core.v
// microcore operand decode, alu add/mask, bias and threshold change
`timescale 1ns/1ps
`default_nettype none
`include "mcad_map.vh"

// What this block does
// RL1 - general operand codes 0-7 select r0-r4, immediate, multiply high and low
// RL2 - codes 8-19 select arith, aux, two jumps, four counters, four end-of-counts
// RL3 - codes 20, 21, 22 select flag, control and status bits registers
// RL4 - code 23 serial data, 24-28 current thresholds, 29 serial address, 30 irq
// RL5 - code 31 selects the other channel communication register
// RL6 - jump operand 0 picks first jump register, 1 the second
// RL7 - add writes sum of two sources to destination, carry into carry flag
// RL8 - both adds update zero, negative, unsigned and signed under/overflow flags
// RL9 - add-immediate adds 4-bit immediate to source, writes destination, sets flags
// RL10 - add-immediate word: opcode 15:10, destination 9:7, immediate 6:3, source 2:0
// RL11 - mask ands register with immediate register; flags none and all ones
// RL12 - mask word: 13-bit opcode in 15:3, register in 2:0
// RL13 - bias changes only outputs this microcore has drive right for
// RL14 - bias target codes for single, strong and grouped structures
// RL15 - control 0 disables, 1 enables; all and all-high include strong
// RL16 - bias word: opcode 15:5, control bit 4, target 3:0
// RL17 - threshold change updates comparator level only with drive right
// RL18 - select 0-9 high-side vds/src alternating, 10-15 low-side vds
// RL19 - 3-bit level field chooses one of eight levels
// RL20 - threshold word: opcode 15:7, select 6:3, level 2:0
// RL21 - bootstrap init mode also shapes high-side source thresholds
// RL22 - 3-bit alu operand selects r0-r4, immediate, multiply high, low
// RL23 - add word: destination 9:7, zero at 6, second 5:3, first 2:0
module mcad_core (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // instruction words from the fetch path
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire [1:0] core_index,
   // operand decode
   input wire [4:0] general_register_operand,
   input wire jump_register_operand,
   output reg [31:0] gen_reg_select_ff,
   output reg [2:0] gen_reg_class_ff,
   output reg [1:0] jump_reg_select_ff,
   // pre-driver side
   input wire bootstrap_init_mode,
   output wire [12:0] bias_enable,
   output wire [47:0] threshold_level,
   // execution status
   output reg exec_done_ff,
   output reg exec_denied_ff,
   output reg exec_unknown_ff,
   output reg [8:0] flags_ff
);

   // -----------------------------------------------------------------
   // instruction decode
   // -----------------------------------------------------------------
   wire is_add;
   wire is_addi;
   wire is_and;
   wire is_bias;
   wire is_chth;

   // operand fields overlap because each opcode reuses the low bits
   wire [2:0] dst_sel;
   wire [2:0] src1_sel;
   wire [2:0] src2_sel;
   wire [3:0] imm4;
   wire [3:0] bias_tgt;
   wire bias_ctrl;
   wire [3:0] fbk_sel;
   wire [2:0] lvl_sel;

   // full opcode compares: a word matching none is flagged unknown
   // and changes no state
   assign is_add = instr_valid & (instr_word[15:10] == `MCAD_OPC_ADD) & ~instr_word[6]; // [RL23]
   assign is_addi = instr_valid & (instr_word[15:10] == `MCAD_OPC_ADDI); // [RL10]
   assign is_and = instr_valid & (instr_word[15:3] == `MCAD_OPC_AND); // [RL12]
   assign is_bias = instr_valid & (instr_word[15:5] == `MCAD_OPC_BIAS); // [RL16]
   assign is_chth = instr_valid & (instr_word[15:7] == `MCAD_OPC_CHTH); // [RL20]

   assign dst_sel = instr_word[9:7]; // [RL10] [RL23]
   assign src2_sel = instr_word[5:3]; // [RL23]
   assign src1_sel = instr_word[2:0]; // [RL10] [RL12] [RL23]
   assign imm4 = instr_word[6:3]; // [RL10]
   assign bias_ctrl = instr_word[4]; // [RL16]
   assign bias_tgt = instr_word[3:0]; // [RL16]
   assign fbk_sel = instr_word[6:3]; // [RL20]
   assign lvl_sel = instr_word[2:0]; // [RL20]

   // -----------------------------------------------------------------
   // alu registers and arithmetic
   // -----------------------------------------------------------------
   // index equals the 3-bit alu operand code: r0-r4, ir, mh, ml
   reg [15:0] alu_ff [0:7]; // [RL22]
   reg [15:0] op_a;
   reg [15:0] op_b;
   reg [16:0] sum17;
   reg [15:0] and_res;

   // one write port: an instruction writes its destination or its mask register
   reg alu_wr;
   reg [2:0] alu_wr_idx;
   reg [15:0] nxt_alu_val;
   reg [8:0] nxt_flags;

   always @* begin
      op_a = alu_ff[src1_sel];
      op_b = is_add ? alu_ff[src2_sel] : {12'h000, imm4}; // [RL9]
      sum17 = {1'b0, op_a} + {1'b0, op_b}; // [RL7]
      and_res = op_a & alu_ff[`MCAD_ALU_IR]; // [RL11]

      alu_wr = 1'b0;
      alu_wr_idx = dst_sel;
      nxt_alu_val = sum17[15:0];
      nxt_flags = flags_ff;

      // flags an instruction does not name keep their value
      if (is_add | is_addi) begin
         alu_wr = 1'b1;
         nxt_flags[`MCAD_FLG_C] = sum17[16]; // [RL7] [RL9]
         nxt_flags[`MCAD_FLG_RZ] = (sum17[15:0] == 16'h0000); // [RL8]
         nxt_flags[`MCAD_FLG_RS] = sum17[15]; // [RL8]
         // an addition cannot wrap below zero, so this flag only clears
         nxt_flags[`MCAD_FLG_UU] = 1'b0; // [RL8]
         nxt_flags[`MCAD_FLG_UO] = sum17[16]; // [RL8]
         // signed flags: both operands share a sign that the result lacks
         nxt_flags[`MCAD_FLG_SU] = op_a[15] & op_b[15] & ~sum17[15]; // [RL8]
         nxt_flags[`MCAD_FLG_SO] = ~op_a[15] & ~op_b[15] & sum17[15]; // [RL8]
      end else if (is_and) begin
         alu_wr = 1'b1;
         alu_wr_idx = src1_sel; // [RL11]
         nxt_alu_val = and_res;
         nxt_flags[`MCAD_FLG_MN] = (and_res == `MCAD_MASK_NONE_VAL); // [RL11]
         nxt_flags[`MCAD_FLG_MM] = (and_res == `MCAD_MASK_ALL_VAL); // [RL11]
      end
   end

   // -----------------------------------------------------------------
   // apb decode
   // -----------------------------------------------------------------
   wire [9:0] widx;
   wire apb_setup;
   wire apb_wr;
   wire idx_is_alu;
   wire idx_is_acc;

   assign widx = paddr[11:2];
   assign apb_setup = psel & ~penable;
   assign apb_wr = psel & penable & pwrite;
   assign idx_is_alu = (widx[9:3] == 7'h00);
   assign idx_is_acc = (widx >= `MCAD_IDX_ACC0) && (widx <= `MCAD_IDX_ACC3);
   // zero wait states: read data is prepared in the setup cycle
   assign pready = 1'b1;

   // word map: 0-7 alu registers, 8 flags, 9 bias, a-b stored levels,
   // c operand decode, 0x184-0x187 drive rights; the rest errors

   // output drive rights, one word per microcore/channel pair
   // core_index picks the word that governs the instruction now running
   reg [10:0] acc_ff [0:3];
   wire [10:0] drive_right;
   assign drive_right = acc_ff[core_index]; // [RL13] [RL17]

   integer i;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < 8; i = i + 1) begin
            alu_ff[i] <= 16'h0000;
         end
         for (i = 0; i < 4; i = i + 1) begin
            acc_ff[i] <= `MCAD_ACC_RST;
         end
         flags_ff <= 9'h000;
      end else begin
         if (apb_wr && idx_is_alu) begin
            alu_ff[widx[2:0]] <= pwdata[15:0];
         end

         if (apb_wr && idx_is_acc) begin
            acc_ff[widx[1:0]] <= pwdata[10:0];
         end

         // an instruction write lands after the bus write and so wins
         if (alu_wr) begin
            alu_ff[alu_wr_idx] <= nxt_alu_val; // [RL7] [RL9] [RL11]
         end
         flags_ff <= nxt_flags; // [RL8]
      end
   end

   // -----------------------------------------------------------------
   // bias structures: hs1-5, ls1-6, hs2 strong, hs4 strong
   // -----------------------------------------------------------------
   wire [12:0] bias_hit;
   wire [12:0] bias_ok;
   genvar g;

   generate
      for (g = 0; g < 13; g = g + 1) begin : g_bias
         localparam integer CODE = (g < 10) ? g : ((g == 10) ? 12 : ((g == 11) ? 10 : 11));
         // a strong structure follows the right of its own high-side driver
         localparam integer OUTI = (g < 11) ? g : ((g == 11) ? 1 : 3);
         localparam [0:0] IN_HS = ((g < 5) || (g > 10)) ? 1'b1 : 1'b0;
         localparam [0:0] IN_LS = ((g >= 5) && (g <= 10)) ? 1'b1 : 1'b0;
         reg en_ff;
         // grouped codes: all and all-high include the strong structures
         assign bias_hit[g] = (bias_tgt == CODE[3:0]) | (bias_tgt == `MCAD_BIAS_ALL)
            | ((bias_tgt == `MCAD_BIAS_ALL_HS) & IN_HS)
            | ((bias_tgt == `MCAD_BIAS_ALL_LS) & IN_LS); // [RL14] [RL15]
         assign bias_ok[g] = drive_right[OUTI]; // [RL13]
         assign bias_enable[g] = en_ff;

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               en_ff <= 1'b0;
            end else if (is_bias && bias_hit[g] && bias_ok[g]) begin
               en_ff <= bias_ctrl; // [RL13] [RL15]
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // feedback comparator thresholds
   // -----------------------------------------------------------------
   wire [15:0] thr_hit;
   wire [15:0] thr_ok;
   wire [47:0] thr_stored;

   generate
      for (g = 0; g < 16; g = g + 1) begin : g_thr
         // 0-9 alternate vds/src per high-side driver, 10-15 low-side vds
         localparam integer OUTI = (g < 10) ? (g / 2) : (g - 5);
         localparam [0:0] HS_SRC = ((g < 10) && (g % 2 == 1)) ? 1'b1 : 1'b0;
         reg [2:0] lvl_ff;
         reg [2:0] eff_ff;
         localparam integer SELI = g;
         // the stored level is what software reads back; the effective
         // copy is what the comparator sees
         assign thr_hit[g] = (fbk_sel == SELI[3:0]); // [RL18]
         assign thr_ok[g] = drive_right[OUTI]; // [RL17]
         assign thr_stored[g*3 +: 3] = lvl_ff;
         assign threshold_level[g*3 +: 3] = eff_ff;

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lvl_ff <= `MCAD_THR_RST;
               eff_ff <= `MCAD_THR_RST;
            end else begin
               if (is_chth && thr_hit[g] && thr_ok[g]) begin
                  lvl_ff <= lvl_sel; // [RL17] [RL19]
               end
               // bootstrap init holds the high-side source comparators
               if (HS_SRC && bootstrap_init_mode) begin
                  eff_ff <= `MCAD_BOOT_SRC_LVL; // [RL21]
               end else begin
                  eff_ff <= lvl_ff;
               end
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // execution status and operand decode outputs
   // -----------------------------------------------------------------
   wire denied;
   wire known;
   reg [2:0] nxt_class;

   // a group order changes the members it may drive and still reports a denial
   assign denied = (is_bias & |(bias_hit & ~bias_ok))
      | (is_chth & |(thr_hit & ~thr_ok)); // [RL13] [RL17]
   assign known = is_add | is_addi | is_and | is_bias | is_chth;

   // class: 0 alu set, 1 arith/aux, 2 jump, 3 counter, 4 end-of-count,
   // 5 flag/control/status, 6 serial/threshold/irq, 7 other channel
   always @* begin
      if (general_register_operand < `MCAD_GREG_FIRST_ARITH) begin
         nxt_class = 3'h0; // [RL1]
      end else if (general_register_operand < `MCAD_GREG_FIRST_JUMP) begin
         nxt_class = 3'h1; // [RL2]
      end else if (general_register_operand < `MCAD_GREG_FIRST_CNT) begin
         nxt_class = 3'h2; // [RL2]
      end else if (general_register_operand < `MCAD_GREG_FIRST_EOC) begin
         nxt_class = 3'h3; // [RL2]
      end else if (general_register_operand < `MCAD_GREG_FIRST_CTRL) begin
         nxt_class = 3'h4; // [RL2]
      end else if (general_register_operand < `MCAD_GREG_FIRST_IO) begin
         nxt_class = 3'h5; // [RL3]
      end else if (general_register_operand < `MCAD_GREG_RXTX) begin
         nxt_class = 3'h6; // [RL4]
      end else begin
         nxt_class = 3'h7; // [RL5]
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_reg_select_ff <= 32'h00000001;
         gen_reg_class_ff <= 3'h0;
         jump_reg_select_ff <= 2'h1;
         exec_done_ff <= 1'b0;
         exec_denied_ff <= 1'b0;
         exec_unknown_ff <= 1'b0;
      end else begin
         // one-hot bit n selects the register whose operand code is n
         gen_reg_select_ff <= 32'h00000001 << general_register_operand; // [RL1] [RL2] [RL3] [RL4] [RL5]
         gen_reg_class_ff <= nxt_class;
         jump_reg_select_ff <= jump_register_operand ? 2'h2 : 2'h1; // [RL6]

         // status pulses stand one cycle per word taken
         exec_done_ff <= known & ~denied;
         exec_denied_ff <= denied;
         exec_unknown_ff <= instr_valid & ~known;
      end
   end

   // -----------------------------------------------------------------
   // apb read path
   // -----------------------------------------------------------------
   reg [31:0] rd_mux;
   reg rd_err;

   always @* begin
      rd_mux = 32'h00000000;
      rd_err = 1'b0;
      if (idx_is_alu) begin
         rd_mux = {16'h0000, alu_ff[widx[2:0]]};
      end else if (idx_is_acc) begin
         rd_mux = {21'h000000, acc_ff[widx[1:0]]};
      end else if (widx == `MCAD_IDX_FLAGS) begin
         rd_mux = {23'h000000, flags_ff};
      end else if (widx == `MCAD_IDX_BIAS) begin
         rd_mux = {19'h00000, bias_enable};
      end else if (widx == `MCAD_IDX_THR_LO) begin
         rd_mux = {8'h00, thr_stored[23:0]};
      end else if (widx == `MCAD_IDX_THR_HI) begin
         rd_mux = {8'h00, thr_stored[47:24]};
      end else if (widx == `MCAD_IDX_DECODE) begin
         rd_mux = gen_reg_select_ff;
      end else begin
         rd_err = 1'b1;
      end
   end

   // unmapped words read as zero and raise the error flag
   // read-only words drop writes and answer without error
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (apb_setup) begin
         prdata <= pwrite ? 32'h00000000 : rd_mux;
         pslverr <= rd_err;
      end
   end

endmodule
`default_nettype wire

// file: mcad_fetch.sv
// fetch path model handing instruction words to the core
`timescale 1ns/1ps
`default_nettype none
module mcad_fetch (
   // clock
   input wire logic pclk,
   // words toward the core
   output var logic instr_valid,
   output var logic [15:0] instr_word
);
   initial begin
      instr_valid = 1'b0;
      instr_word = 16'h0000;
   end
   // idle word is the inverse of the last one so a stale word never looks fresh
   task send(input logic [15:0] w);
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_word <= w;
      @(posedge pclk);
      instr_valid <= 1'b0;
      instr_word <= ~w;
   endtask
endmodule
`default_nettype wire

// file: mcad_map.vh
// constants for the microcore operand and alu decode block
`ifndef MCAD_MAP_VH
`define MCAD_MAP_VH

// --------------------------------------------------------------------
// instruction opcodes and fixed fields
// --------------------------------------------------------------------
`define MCAD_OPC_ADD 6'h0a
`define MCAD_OPC_ADDI 6'h06
`define MCAD_OPC_AND 13'h05d9
`define MCAD_OPC_BIAS 11'h1b1
`define MCAD_OPC_CHTH 9'h05f

// --------------------------------------------------------------------
// operand codes
// --------------------------------------------------------------------
`define MCAD_ALU_R0 3'h0
`define MCAD_ALU_IR 3'h5
`define MCAD_ALU_MH 3'h6
`define MCAD_ALU_ML 3'h7
`define MCAD_GREG_FIRST_ARITH 5'h08
`define MCAD_GREG_FIRST_JUMP 5'h0a
`define MCAD_GREG_FIRST_CNT 5'h0c
`define MCAD_GREG_FIRST_EOC 5'h10
`define MCAD_GREG_FIRST_CTRL 5'h14
`define MCAD_GREG_FIRST_IO 5'h17
`define MCAD_GREG_RXTX 5'h1f
`define MCAD_BIAS_ALL 4'hd
`define MCAD_BIAS_ALL_HS 4'he
`define MCAD_BIAS_ALL_LS 4'hf
`define MCAD_MASK_NONE_VAL 16'h0000
`define MCAD_MASK_ALL_VAL 16'hffff

// --------------------------------------------------------------------
// flag register bit positions
// --------------------------------------------------------------------
`define MCAD_FLG_C 0
`define MCAD_FLG_RZ 1
`define MCAD_FLG_RS 2
`define MCAD_FLG_UU 3
`define MCAD_FLG_UO 4
`define MCAD_FLG_SU 5
`define MCAD_FLG_SO 6
`define MCAD_FLG_MN 7
`define MCAD_FLG_MM 8

// --------------------------------------------------------------------
// apb word indices (byte address = 4 * index) and reset values
// --------------------------------------------------------------------
`define MCAD_IDX_FLAGS 10'h008
`define MCAD_IDX_BIAS 10'h009
`define MCAD_IDX_THR_LO 10'h00a
`define MCAD_IDX_THR_HI 10'h00b
`define MCAD_IDX_DECODE 10'h00c
`define MCAD_IDX_ACC0 10'h184
`define MCAD_IDX_ACC3 10'h187
`define MCAD_ACC_RST 11'h000
`define MCAD_THR_RST 3'h0
`define MCAD_BOOT_SRC_LVL 3'h0

`endif

// file: tb.sv
// self-checking bench for the operand and alu decode core
`timescale 1ns/1ps
`default_nettype none
`include "mcad_map.vh"
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ivld, jmp, boot, done, den, unk, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, gsel, q;
   logic [15:0] iword, a, b;
   logic [16:0] s;
   logic [1:0] core, jsel;
   logic [4:0] gop;
   logic [2:0] gcls, l;
   logic [2:0] lv [16];
   logic [12:0] bias, be, m, ok;
   logic [47:0] thr;
   logic [8:0] flags, fl;
   logic [10:0] rt;
   int failures, checks_done, seed, cyc, i, k, t;
   mcad_core mcad_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .instr_valid(ivld), .instr_word(iword), .core_index(core),
      .general_register_operand(gop), .jump_register_operand(jmp), .gen_reg_select_ff(gsel),
      .gen_reg_class_ff(gcls), .jump_reg_select_ff(jsel), .bootstrap_init_mode(boot),
      .bias_enable(bias), .threshold_level(thr), .exec_done_ff(done), .exec_denied_ff(den),
      .exec_unknown_ff(unk), .flags_ff(flags));
   mcad_fetch mcad_fetch_i (.pclk(pclk), .instr_valid(ivld), .instr_word(iword));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task ex(input logic [15:0] w);
      mcad_fetch_i.send(w);
      @(negedge pclk);
   endtask
   function automatic [8:0] addf(input [15:0] x, input [15:0] y, input [8:0] o);
      logic [16:0] r;
      r = x + y;
      addf = {o[8:7], ~x[15] & ~y[15] & r[15], x[15] & y[15] & ~r[15], r[16], 1'b0, r[15],
         r[15:0] == 16'h0, r[16]};
   endfunction
   function automatic [2:0] cls(input [4:0] c);
      cls = c < 8 ? 0 : c < 10 ? 1 : c < 12 ? 2 : c < 16 ? 3 : c < 20 ? 4 : c < 23 ? 5 : c < 31 ? 6 : 7;
   endfunction
   function automatic [12:0] bmask(input [3:0] g);
      case (g)
         4'ha: bmask = 13'h0800;
         4'hb: bmask = 13'h1000;
         4'hc: bmask = 13'h0400;
         4'hd: bmask = 13'h1fff;
         4'he: bmask = 13'h181f;
         4'hf: bmask = 13'h07e0;
         default: bmask = 13'h0001 << g;
      endcase
   endfunction
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         results;
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, jmp, boot} = 6'h0;
      {paddr, pwdata, core, gop, failures, checks_done, seed} = 0;
      seed = 99143;
      fl = 9'h0;
      be = 13'h0;
      for (i = 0; i < 16; i++) lv[i] = 3'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(gsel, 32'h1);
      chk(jsel, 2'h1);
      for (i = 0; i < 34; i++) begin
         @(posedge pclk);
         gop <= i[4:0];
         jmp <= i[0];
         @(posedge pclk);
         @(negedge pclk);
         chk(gsel, 32'h1 << i[4:0]);
         chk(gcls, cls(i[4:0]));
         chk(jsel, i[0] ? 2'h2 : 2'h1);
      end
      $display("test operands over");
      for (i = 0; i < 24; i++) begin
         a = i == 0 ? 16'hffff : i == 1 ? 16'h8000 : i == 2 ? 16'h7fff : $random(seed);
         b = i == 0 ? 16'h0001 : i == 1 ? 16'h8000 : i == 2 ? 16'h0001 : $random(seed);
         k = i % 8;
         t = (i + 3) % 8;
         apb(1'b1, k * 4, {$random(seed), a});
         apb(1'b1, t * 4, {16'h0, b});
         ex({`MCAD_OPC_ADD, i[2:0] ^ 3'h5, 1'b0, t[2:0], k[2:0]});
         s = a + b;
         fl = addf(a, b, fl);
         apb(1'b0, (i[2:0] ^ 3'h5) * 4, 32'h0);
         chk(q, s[15:0]);
         chk(flags, fl);
         l = $random(seed);
         ex({`MCAD_OPC_ADDI, t[2:0], l, 1'b1, k[2:0]});
         fl = addf(a, {12'h0, l, 1'b1}, fl);
         apb(1'b0, t * 4, 32'h0);
         s = a + {l, 1'b1};
         chk(q, s[15:0]);
         chk(flags, fl);
      end
      ex({`MCAD_OPC_ADD, 3'h1, 1'b1, 6'h0});
      chk(unk, 1'b1);
      $display("test adds over");
      for (i = 0; i < 6; i++) begin
         a = i == 0 ? 16'hffff : $random(seed);
         b = i == 0 ? 16'hffff : i == 1 ? ~a : $random(seed);
         apb(1'b1, 12'h014, {16'h0, b});
         apb(1'b1, i % 5 * 4, {16'h0, a});
         ex({`MCAD_OPC_AND, i[2:0] % 3'h5});
         apb(1'b0, i % 5 * 4, 32'h0);
         chk(q, a & b);
         fl[8:7] = {(a & b) == 16'hffff, (a & b) == 16'h0};
         chk(flags, fl);
      end
      apb(1'b0, 12'h034, 32'h0);
      chk({e, q}, 33'h100000000);
      $display("test masks over");
      for (i = 0; i < 32; i++) begin
         rt = i == 0 ? 11'h7ff : $random(seed);
         k = $random(seed);
         apb(1'b1, 12'h610 + k[1:0] * 4, {$random(seed), rt});
         core <= k[1:0];
         apb(1'b0, 12'h610 + k[1:0] * 4, 32'h0);
         chk(q, rt);
         ok = {rt[3], rt[1], rt};
         m = bmask(i[3:0]);
         ex({`MCAD_OPC_BIAS, ~i[4], i[3:0]});
         be = i[4] ? be & ~(m & ok) : be | (m & ok);
         chk(bias, be);
         chk(den, (m & ~ok) != 13'h0);
         chk(done, (m & ~ok) == 13'h0);
      end
      $display("test bias over");
      for (i = 0; i < 32; i++) begin
         rt = i < 16 ? 11'h7ff : $random(seed);
         apb(1'b1, 12'h610 + core * 4, {21'h0, rt});
         t = i % 16;
         l = $random(seed);
         ex({`MCAD_OPC_CHTH, t[3:0], l});
         e = t < 10 ? rt[t / 2] : rt[t - 5];
         if (e) lv[t] = l;
         chk(den, !e);
         chk(done, e);
         @(negedge pclk);
         chk(thr[3 * t +: 3], lv[t]);
      end
      @(posedge pclk);
      boot <= 1'b1;
      repeat (3) @(negedge pclk);
      for (k = 0; k < 16; k++) chk(thr[3 * k +: 3], k < 10 && k % 2 ? 3'h0 : lv[k]);
      $display("test thresholds over");
      results;
   end
endmodule
`default_nettype wire
